// ===== lhbp_cfg.svh
`ifndef LHBP_CFG_SVH
`define LHBP_CFG_SVH
// Bus widths
`define LHBP_DATA_W      16
`define LHBP_ADDR_W      16
// Polarity and mode configuration bit positions
`define LHBP_CFG_RW_MODE  0
`define LHBP_CFG_POL_ACK  1
`define LHBP_CFG_POL_CS   2
`define LHBP_CFG_POL_RD   3
`define LHBP_CFG_POL_WR   4
`define LHBP_CFG_POL_ALE  5
`define LHBP_CFG_W        6
// Reset values
`define LHBP_CFG_RST      6'h00
`define LHBP_CONF_RST     32'h0000_0000
// Host phase timing as counter loads; each phase lasts one clock cycle more
`define LHBP_SETUP_CYC    4'h2
`define LHBP_ACTIVE_CYC   4'h4
`define LHBP_HOLD_CYC     4'h2
`endif

// ===== lhbp_pkg.sv
package lhbp_pkg;
  // Addressing mode
  typedef enum logic [1:0] {
    LHBP_MUX   = 2'b00,
    LHBP_DEMUX = 2'b01,
    LHBP_INDEX = 2'b10
  } lhbp_mode_t;
  // Host cycle sequencer
  typedef enum logic [2:0] {
    LHBP_IDLE   = 3'b000,
    LHBP_LATCH  = 3'b001,
    LHBP_SETUP  = 3'b010,
    LHBP_ACTIVE = 3'b011,
    LHBP_HOLD   = 3'b100,
    LHBP_GAP    = 3'b101
  } lhbp_hstate_t;
endpackage

// ===== lhbp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lhbp_if;
  logic [15:0] ad_host;     // Host drive of data/address lines
  logic [15:0] ad_host_oe_n;
  logic [15:0] ad_dev;      // Device drive of data/address lines
  logic [15:0] ad_dev_oe_n;
  logic [15:0] addr;        // Demultiplexed address
  logic        cs;
  logic        rd;          // Read or direction
  logic        wr;          // Write or transfer_strobe
  logic        low_latch_strobe;
  logic        endian;
  logic [1:0]  lane_enables;
  logic        wait_ack;
  logic        wait_ack_oe_n;
  wire  [15:0] ad;          // Resolved wire level per bit
  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_res
      assign ad[g] = !ad_dev_oe_n[g] ? ad_dev[g] :
                     !ad_host_oe_n[g] ? ad_host[g] : 1'b0;
    end
  endgenerate
  modport dev  (input ad, addr, cs, rd, wr, low_latch_strobe, endian,
                lane_enables, output ad_dev, ad_dev_oe_n, wait_ack,
                wait_ack_oe_n);
  modport host (input ad, wait_ack, output ad_host, ad_host_oe_n, addr,
                cs, rd, wr, low_latch_strobe, endian, lane_enables);
endinterface
`default_nettype wire

// ===== lhbp_dev.sv
`include "lhbp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module lhbp_dev #(
  parameter int DW_WORDS = 4  // Backing store size in DWORDs
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic [1:0]                mode_i,
  input  wire logic                      bus16_i,
  input  wire logic [`LHBP_CFG_W-1:0]    cfg_i,
  input  wire logic                      ack_en_i,
  lhbp_if.dev                            bus,
  output logic      [31:0]               conf_o,
  output logic      [`LHBP_ADDR_W-1:0]   addr_o
);
  localparam int AW = $clog2(DW_WORDS);
  // Store index is a plain address slice, so size must be a power of two
  if (DW_WORDS < 2 || DW_WORDS > 256 || (1 << AW) != DW_WORDS)
  begin : g_bad_words
    $error("lhbp_dev: DW_WORDS must be a power of two from 2 to 256");
  end

  typedef struct packed {
    logic [1:0]  s_cs;
    logic [1:0]  s_rd;
    logic [1:0]  s_wr;
    logic [1:0]  s_ale;
    logic [1:0]  s_end;
    logic [15:0] s_ad_a;
    logic [15:0] s_ad_b;
    logic [15:0] s_addr_a;
    logic [15:0] s_addr_b;
    logic        wr_act;
    logic        rd_act;
    logic [15:0] wdata;
    logic [15:0] latch_addr;
    logic [15:0] rdata;
    logic        drive;
    logic [31:0] conf;
    logic [DW_WORDS-1:0][31:0] mem;
  } dev_st_t;

  dev_st_t st_ff;
  dev_st_t nxt_st;

  logic cs_n, rd_n, wr_n, ale_n, is_rd, is_wr;
  logic [15:0] cur_addr;
  logic        endian;
  logic [1:0]  lane;
  logic [AW-1:0] dw;
  logic [31:0] word32;
  logic [31:0] wmerge;

  // Normalised controls from second sync stage
  always_comb
  begin
    cs_n  = st_ff.s_cs[1] ^ cfg_i[`LHBP_CFG_POL_CS];
    rd_n  = st_ff.s_rd[1] ^ cfg_i[`LHBP_CFG_POL_RD];
    wr_n  = st_ff.s_wr[1] ^ cfg_i[`LHBP_CFG_POL_WR];
    ale_n = st_ff.s_ale[1] ^ cfg_i[`LHBP_CFG_POL_ALE];
    if (cfg_i[`LHBP_CFG_RW_MODE])
    begin
      // Direction low means read; strobe qualifies
      is_rd = cs_n && wr_n && !rd_n;
      is_wr = cs_n && wr_n && rd_n;
    end
    else
    begin
      is_rd = cs_n && rd_n;
      is_wr = cs_n && wr_n;
    end
  end

  // Address source and byte lane selection
  always_comb
  begin
    if (mode_i == lhbp_pkg::LHBP_MUX)
      cur_addr = st_ff.latch_addr;
    else
      cur_addr = st_ff.s_addr_b;
    if (mode_i == lhbp_pkg::LHBP_INDEX)
      endian = st_ff.conf[0];
    else
      endian = st_ff.s_end[1];
    // Lane follows address only; endianness swaps bytes inside the word
    lane = bus16_i ? {cur_addr[1], 1'b0} : cur_addr[1:0];
    dw = cur_addr[AW+1:2];
  end

  // Selected DWORD and write merge
  always_comb
  begin
    word32 = (mode_i == lhbp_pkg::LHBP_INDEX) ? st_ff.conf
                                              : st_ff.mem[dw];
    wmerge = word32;
    if (bus16_i)
    begin
      if (lane[1])
        wmerge[31:16] = endian ? {st_ff.wdata[7:0], st_ff.wdata[15:8]}
                               : st_ff.wdata;
      else
        wmerge[15:0] = endian ? {st_ff.wdata[7:0], st_ff.wdata[15:8]}
                              : st_ff.wdata;
    end
    else
      wmerge[lane*8 +: 8] = st_ff.wdata[7:0];
  end

  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s_cs   = {st_ff.s_cs[0], bus.cs};
    nxt_st.s_rd   = {st_ff.s_rd[0], bus.rd};
    nxt_st.s_wr   = {st_ff.s_wr[0], bus.wr};
    nxt_st.s_ale  = {st_ff.s_ale[0], bus.low_latch_strobe};
    nxt_st.s_end  = {st_ff.s_end[0], bus.endian};
    nxt_st.s_ad_a = bus.ad;
    nxt_st.s_ad_b = st_ff.s_ad_a;
    nxt_st.s_addr_a = bus.addr;
    nxt_st.s_addr_b = st_ff.s_addr_a;
    nxt_st.wr_act = is_wr;
    nxt_st.rd_act = is_rd;
    // Transparent while latch strobe active; holds from trailing edge
    if (mode_i == lhbp_pkg::LHBP_MUX && ale_n)
      nxt_st.latch_addr = st_ff.s_ad_b;
    // Track data while write active; upper half only in 16-bit
    if (is_wr)
      nxt_st.wdata = bus16_i ? st_ff.s_ad_b
                             : {8'h00, st_ff.s_ad_b[7:0]};
    // Commit on trailing edge of write strobe
    if (st_ff.wr_act && !is_wr)
    begin
      if (mode_i == lhbp_pkg::LHBP_INDEX)
        nxt_st.conf = wmerge;
      else
        nxt_st.mem[dw] = wmerge;
    end
    // Read data placed from addressed lane
    if (bus16_i)
    begin
      nxt_st.rdata = lane[1] ? word32[31:16] : word32[15:0];
      if (endian)
        nxt_st.rdata = {nxt_st.rdata[7:0], nxt_st.rdata[15:8]};
    end
    else
      nxt_st.rdata = {8'h00, word32[lane*8 +: 8]};
    nxt_st.drive = is_rd;
    if (rst_i)
    begin
      nxt_st.conf = `LHBP_CONF_RST;
      nxt_st.latch_addr = 16'h0000;
      nxt_st.wr_act = 1'b0;
      nxt_st.rd_act = 1'b0;
      nxt_st.drive = 1'b0;
      nxt_st.mem = '0;
    end
  end

  always_ff @(posedge clk_i)
    st_ff <= nxt_st;

  // Pin drive: upper lines only in 16-bit reads
  always_comb
  begin
    bus.ad_dev = st_ff.rdata;
    bus.ad_dev_oe_n[7:0]  = {8{!st_ff.drive}};
    bus.ad_dev_oe_n[15:8] = {8{!(st_ff.drive && bus16_i)}};
    // Lane enables unused; ack held inactive
    bus.wait_ack = cfg_i[`LHBP_CFG_POL_ACK];
    bus.wait_ack_oe_n = !ack_en_i;
  end

  assign conf_o = st_ff.conf;
  assign addr_o = cur_addr;
endmodule
`default_nettype wire

// ===== lhbp_host.sv
`include "lhbp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module lhbp_host (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [1:0]             mode_i,
  input  wire logic                   bus16_i,
  input  wire logic [`LHBP_CFG_W-1:0] cfg_i,
  input  wire logic                   req_i,
  input  wire logic                   we_i,
  input  wire logic                   skip_latch_i,
  input  wire logic                   endian_i,
  input  wire logic [15:0]            addr_i,
  input  wire logic [15:0]            wdata_i,
  output logic                        busy_o,
  output logic                        done_o,
  output logic      [15:0]            rdata_o,
  lhbp_if.host                        bus
);
  typedef struct packed {
    lhbp_pkg::lhbp_hstate_t st;
    logic [3:0]  cnt;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        done;
  } host_st_t;

  host_st_t st_ff;
  host_st_t nxt_st;
  logic act, dir, stb, lat, drv_d;

  // Sequencer
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    case (st_ff.st)
      lhbp_pkg::LHBP_IDLE:
        if (req_i)
        begin
          nxt_st.we = we_i;
          nxt_st.addr = addr_i;
          nxt_st.wdata = wdata_i;
          nxt_st.cnt = `LHBP_SETUP_CYC;
          nxt_st.st = (mode_i == lhbp_pkg::LHBP_MUX && !skip_latch_i)
                      ? lhbp_pkg::LHBP_LATCH : lhbp_pkg::LHBP_SETUP;
        end
      lhbp_pkg::LHBP_LATCH:
        if (st_ff.cnt == 4'h0)
        begin
          nxt_st.cnt = `LHBP_SETUP_CYC;
          nxt_st.st = lhbp_pkg::LHBP_SETUP;
        end
        else
          nxt_st.cnt = st_ff.cnt - 4'h1;
      lhbp_pkg::LHBP_SETUP:
        if (st_ff.cnt == 4'h0)
        begin
          nxt_st.cnt = `LHBP_ACTIVE_CYC;
          nxt_st.st = lhbp_pkg::LHBP_ACTIVE;
        end
        else
          nxt_st.cnt = st_ff.cnt - 4'h1;
      lhbp_pkg::LHBP_ACTIVE:
        if (st_ff.cnt == 4'h0)
        begin
          nxt_st.rdata = bus16_i ? bus.ad : {8'h00, bus.ad[7:0]};
          nxt_st.cnt = `LHBP_HOLD_CYC;
          nxt_st.st = lhbp_pkg::LHBP_HOLD;
        end
        else
          nxt_st.cnt = st_ff.cnt - 4'h1;
      lhbp_pkg::LHBP_HOLD:
        if (st_ff.cnt == 4'h0)
        begin
          nxt_st.done = 1'b1;
          nxt_st.st = lhbp_pkg::LHBP_GAP;
        end
        else
          nxt_st.cnt = st_ff.cnt - 4'h1;
      lhbp_pkg::LHBP_GAP:
        nxt_st.st = lhbp_pkg::LHBP_IDLE;
      default:
        nxt_st.st = lhbp_pkg::LHBP_IDLE;
    endcase
    if (rst_i)
    begin
      nxt_st.st = lhbp_pkg::LHBP_IDLE;
      nxt_st.cnt = 4'h0;
      nxt_st.done = 1'b0;
      nxt_st.rdata = 16'h0000;
    end
  end

  always_ff @(posedge clk_i)
    st_ff <= nxt_st;

  // Pin drive in active-high form, then polarity applied
  always_comb
  begin
    lat = st_ff.st == lhbp_pkg::LHBP_LATCH;
    act = st_ff.st == lhbp_pkg::LHBP_ACTIVE;
    drv_d = st_ff.st == lhbp_pkg::LHBP_SETUP ||
            st_ff.st == lhbp_pkg::LHBP_ACTIVE ||
            st_ff.st == lhbp_pkg::LHBP_HOLD;
    dir = st_ff.we;
    stb = act;
    if (cfg_i[`LHBP_CFG_RW_MODE])
    begin
      bus.rd = (drv_d && dir) ^ cfg_i[`LHBP_CFG_POL_RD];
      bus.wr = stb ^ cfg_i[`LHBP_CFG_POL_WR];
    end
    else
    begin
      bus.rd = (act && !st_ff.we) ^ cfg_i[`LHBP_CFG_POL_RD];
      bus.wr = (act && st_ff.we) ^ cfg_i[`LHBP_CFG_POL_WR];
    end
    bus.cs = (drv_d || lat) ^ cfg_i[`LHBP_CFG_POL_CS];
    bus.low_latch_strobe = lat ^ cfg_i[`LHBP_CFG_POL_ALE];
    bus.addr = st_ff.addr;
    bus.endian = endian_i;
    bus.lane_enables = 2'b00;
    // Address on both halves while latching
    bus.ad_host = lat ? st_ff.addr : st_ff.wdata;
    bus.ad_host_oe_n = 16'hffff;
    if (mode_i == lhbp_pkg::LHBP_MUX && (lat || (drv_d && !bus16_i)))
      bus.ad_host_oe_n[15:8] = 8'h00;  // upper address may stay
    if (lat)
      bus.ad_host_oe_n[7:0] = 8'h00;
    if (drv_d && st_ff.we)
    begin
      bus.ad_host_oe_n[7:0] = 8'h00;
      if (bus16_i)
        bus.ad_host_oe_n[15:8] = 8'h00;
    end
    if (mode_i == lhbp_pkg::LHBP_MUX && drv_d && !bus16_i)
      bus.ad_host[15:8] = st_ff.addr[15:8];
  end

  assign busy_o = st_ff.st != lhbp_pkg::LHBP_IDLE;
  assign done_o = st_ff.done;
  assign rdata_o = st_ff.rdata;
endmodule
`default_nettype wire

// ===== lhbp_monitor.sv
`include "lhbp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module lhbp_monitor (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   bus16_i,
  input wire logic [`LHBP_CFG_W-1:0] cfg_i,
  input wire logic                   ack_en_i,
  input wire logic                   cs,
  input wire logic                   rd,
  input wire logic                   wr,
  input wire logic [15:0]            ad_dev_oe_n,
  input wire logic                   wait_ack,
  input wire logic                   wait_ack_oe_n
);
  logic sel;
  logic dir;
  logic stb;
  logic rd_a;
  logic wr_a;
  // Pins brought to active-high form
  assign sel  = cs ^ cfg_i[`LHBP_CFG_POL_CS];
  assign dir  = rd ^ cfg_i[`LHBP_CFG_POL_RD];
  assign stb  = wr ^ cfg_i[`LHBP_CFG_POL_WR];
  assign rd_a = sel && (cfg_i[`LHBP_CFG_RW_MODE] ? stb && !dir : dir);
  assign wr_a = sel && (cfg_i[`LHBP_CFG_RW_MODE] ? stb && dir : stb);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  upper_free_a: assert property (!bus16_i |-> &ad_dev_oe_n[15:8])
    else $error("upper lines driven in byte mode");
  ack_level_a: assert property (
    ack_en_i && !wait_ack_oe_n |-> wait_ack == cfg_i[`LHBP_CFG_POL_ACK])
    else $error("ack not at inactive level");
  ack_off_a: assert property (!ack_en_i |-> wait_ack_oe_n)
    else $error("ack driven while disabled");
  ack_on_a: assert property (ack_en_i [*3] |-> !wait_ack_oe_n)
    else $error("ack not driven while enabled");
  read_drive_a: assert property (rd_a [*5] |->
    (bus16_i ? ad_dev_oe_n == 16'h0000 : ad_dev_oe_n[7:0] == 8'h00))
    else $error("read data not driven");
  idle_float_a: assert property (!rd_a [*5] |-> &ad_dev_oe_n)
    else $error("lines driven outside read");
  write_float_a: assert property (wr_a |-> &ad_dev_oe_n)
    else $error("lines driven during write");
  strobe_len_a: assert property (
    $rose(rd_a || wr_a) |-> (rd_a || wr_a) [*5] ##1 !(rd_a || wr_a))
    else $error("strobe length wrong");
  ctrl_hold_a: assert property (
    (rd_a || wr_a) ##1 (rd_a || wr_a) |-> $stable(rd) && $stable(wr))
    else $error("control moved during strobe");
endmodule
`default_nettype wire

// ===== legacy_host_bus_port_tb.sv
`include "lhbp_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module legacy_host_bus_port_tb;
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic [1:0]             mode_i = 2'h0;
  logic                   bus16_i = 1'b0;
  logic [`LHBP_CFG_W-1:0] cfg_i = '0;
  logic                   ack_en_i = 1'b0;
  logic                   req_i = 1'b0;
  logic                   we_i = 1'b0;
  logic                   skip_i = 1'b0;
  logic                   endian_i = 1'b0;
  logic [15:0]            addr_i = 16'h0000;
  logic [15:0]            wdata_i = 16'h0000;
  logic                   busy_o;
  logic                   done_o;
  logic [15:0]            rdata_o;
  logic [15:0]            addr_o;
  logic [31:0]            conf_o;
  logic [31:0]            nt;
  logic [31:0]            notes[$];
  int                     n_mismatch = 0;
  int                     checks_done = 0;
  lhbp_if bus_if ();
  lhbp_dev u_lhbp_dev (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i),
    .bus16_i(bus16_i), .cfg_i(cfg_i), .ack_en_i(ack_en_i), .bus(bus_if),
    .conf_o(conf_o), .addr_o(addr_o));
  lhbp_host u_lhbp_host (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i),
    .bus16_i(bus16_i), .cfg_i(cfg_i), .req_i(req_i), .we_i(we_i),
    .skip_latch_i(skip_i), .endian_i(endian_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o), .bus(bus_if));
  lhbp_monitor u_lhbp_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .bus16_i(bus16_i), .cfg_i(cfg_i), .ack_en_i(ack_en_i),
    .cs(bus_if.cs), .rd(bus_if.rd), .wr(bus_if.wr),
    .ad_dev_oe_n(bus_if.ad_dev_oe_n), .wait_ack(bus_if.wait_ack),
    .wait_ack_oe_n(bus_if.wait_ack_oe_n));
  // Clock generation
  always #50 clk_i = ~clk_i;
  // One transfer; note holds mask and expected read data
  task automatic xfer(input logic w, input logic sk, input logic en,
                      input logic [15:0] a, input logic [15:0] d,
                      input logic [15:0] m, input logic [15:0] e);
    notes.push_back({m, e});
    do @(posedge clk_i); while (busy_o !== 1'b0);
    req_i <= 1'b1;
    we_i <= w;
    skip_i <= sk;
    endian_i <= en;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    req_i <= 1'b0;
    do @(posedge clk_i); while (done_o !== 1'b1);
  endtask
  // New random polarities under reset
  task automatic setup(input logic [1:0] m, input logic b);
    logic [31:0] r;
    r = $urandom;
    @(posedge clk_i);
    rst_i <= 1'b1;
    mode_i <= m;
    bus16_i <= b;
    cfg_i <= r[`LHBP_CFG_W-1:0];
    ack_en_i <= r[8];
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Result watcher compares read data with oldest note
  always @(negedge clk_i)
  begin
    if (done_o === 1'b1 && notes.size() > 0)
    begin
      nt = notes.pop_front();
      if (nt[31:16] != 16'h0000)
        `CHK("rdata", nt[15:0], rdata_o & nt[31:16])
    end
  end
  // Main sequence over modes and widths
  initial
  begin
    logic [15:0] a;
    logic [31:0] v;
    int          k;
    void'($urandom(32'h7314));
    repeat (16) @(posedge clk_i);
    for (int p = 0; p < 10; p++)
    begin
      k = p % 5;
      setup(k == 0 ? 2'h0 : (k < 3 ? 2'h1 : 2'h2), k == 2 || k == 4);
      v = $urandom & 32'hffff_fffe;
      a = (k > 2) ? 16'h0000 : {v[17:4], 2'b00};
      if (!bus16_i)
      begin
        for (int b = 0; b < 4; b++)
          xfer(1, 0, 0, 16'(a + b), {v[31:24], v[8*b+:8]}, 0, 0);
        for (int b = 3; b >= 0; b--)
          xfer(0, 0, 0, 16'(a + b), 0, 16'h00ff, {8'h00, v[8*b+:8]});
        if (k == 0)
        begin
          xfer(0, 1, 0, 16'hffff, 0, 16'h00ff, {8'h00, v[7:0]});
          `CHK("addr", a, addr_o)
        end
      end
      else
      begin
        xfer(1, 0, 0, a, v[15:0], 0, 0);
        xfer(1, 0, 0, a + 2, v[31:16], 0, 0);
        xfer(0, 0, 1, a + 2, 0, 16'hffff,
             k == 2 ? {v[23:16], v[31:24]} : v[31:16]);
        xfer(0, 0, 0, a, 0, 16'hffff, v[15:0]);
      end
      if (k > 2)
        `CHK("conf", v, conf_o)
    end
    end_of_test();
  end
  // Watchdog
  initial
  begin
    #(30000 * 100);
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
